// ---- hdl/iot_pkg.sv ----
// constants, register map and state encoding of the i/o and trigger self-test
// assumes a single 40 MHz core clock shared with the host processor
package iot_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_FAIL   = 8'h08;
    localparam logic [7:0] OFS_NORM   = 8'h0c;

    // field positions
    localparam int CTRL_START_BIT = 0;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_DONE_BIT  = 1;
    localparam int STAT_FAIL_BIT  = 2;
    localparam int NORM_DOUT_LSB  = 0;
    localparam int NORM_TOUT_LSB  = 4;
    localparam int FAIL_CNT_LSB   = 16;

    // reset values
    localparam logic [3:0]  NORM_DOUT_RST = 4'h0;
    localparam logic [6:0]  NORM_TOUT_RST = 7'h00;
    localparam logic [15:0] FAIL_ID_RST   = 16'h0000;

    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETTLE_NS     = 1000;
    localparam int BYTE_TMO_NS   = 100000;
    localparam logic [11:0] SETTLE_CYC =
        12'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] BYTE_TMO_CYC = 12'(BYTE_TMO_NS / CLK_PERIOD_NS);

    // subtest sequence indices
    localparam logic [4:0] SUB_DIN    = 5'h04;
    localparam logic [4:0] SUB_HSK    = 5'h05;
    localparam logic [4:0] SUB_DATA   = 5'h06;
    localparam logic [4:0] SUB_TRIG0  = 5'h07;
    localparam logic [4:0] SUB_XTRIG  = 5'h0d;
    localparam logic [4:0] SUB_SHORT0 = 5'h0f;
    localparam logic [4:0] SUB_LAST   = 5'h16;

    // trigger source index of the group-execute-trigger event
    localparam logic [2:0] SRC_GET = 3'h7;

    // test numbers as reported in the failure identity
    localparam logic [7:0] TEST_DIO  = 8'h67;
    localparam logic [7:0] TEST_BUS  = 8'h68;
    localparam logic [7:0] TEST_TRIG = 8'h69;

    // bytes sent to the bus interface data-out register
    localparam logic [7:0] HSK_BYTE_A   = 8'h55;
    localparam logic [7:0] HSK_BYTE_B   = 8'haa;
    localparam logic [7:0] DIO1_DRIVE   = 8'h01;
    localparam logic [7:0] DIO1_RELEASE = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_HI    = 3'b011,
        ST_LO    = 3'b010,
        ST_EVAL  = 3'b110,
        ST_NEXT  = 3'b111,
        ST_DONE  = 3'b101
    } iot_state_t;

endpackage

// ---- hdl/iot_self_test.sv ----
// self-test sequencer for the digital i/o port, bus handshake and triggers
// assumes all inputs synchronous to core_clk; pin wires resolved outside
//
// Contract
// [R1] four open-collector outputs and one ttl input line are provided.
// [R2] port bits a..d drive digital outputs one..four in order.
// [R3] loopback: output n returns on port bit n+1, output four on bit a.
// [R4] each port bit switches between output and input for self-test.
// [R5] 103.1: bits a,c out, b,d in; toggle a, see level on b.
// [R6] 103.2: bits b,d out, a,c in; toggle b, see level on c.
// [R7] 103.3 and 103.4 check outputs three and four the same way.
// [R8] 103.5 passes only if the digital input reads high when open.
// [R9] 104.1: acceptor on, write bytes, each byte-out handshake must complete.
// [R10] 104.2: drive then release data line one, check sampled level.
// [R11] seven trigger outputs, eight trigger inputs, any input can be armed.
// [R12] lines 1-6 trigger bus; out 7 channel ready; in 7 ext; in 8 get.
// [R13] bus trigger inputs idle high; device pulls low via its trigger output.
// [R14] 105.1-105.6 arm input n, pulse output n, pass only on detection.
// [R15] 105.7 arm external input, pulse channel ready; detection fails.
// [R16] 105.8 arm input eight, command get event, pass only on detection.
// [R17] 105.11-105.18 arm one input, toggle all others; detection fails.
// [R18] any failure flags overall fail and keeps the failing subtest id.
// [R19] subtests run ascending; normal directions and triggers restored after.
module iot_self_test (
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      reset_n,
    // register port
    input  wire logic [iot_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [iot_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [iot_pkg::DATA_W-1:0] reg_rdata_r,
    // general port bits a..d, pins of the digital outputs
    input  wire logic [3:0]                out_port_in,
    output logic      [3:0]                out_port_out_r,
    output logic      [3:0]                out_port_oe_n_r,
    // digital input and bus data line samples
    input  wire logic                      dig_in_sample_bit,
    input  wire logic                      bus_data_sample_bit,
    // bus interface
    output logic                           acceptor_en_r,
    output logic      [7:0]                bus_dout_r,
    output logic                           bus_dout_wr_r,
    output logic                           bus_get_cmd_r,
    input  wire logic                      bus_byte_out_done,
    // triggers
    output logic      [6:0]                trig_out_lines_r,
    input  wire logic [7:0]                trig_in_lines,
    // result
    output logic                           test_busy_r,
    output logic                           test_fail_r
);
    import iot_pkg::*;

    function automatic logic [15:0] subtest_id(input logic [4:0] s);
        logic [7:0] n;
        n = {3'h0, s};
        if (s < SUB_HSK)
            subtest_id = {TEST_DIO, 8'(n + 8'h01)};
        else if (s < SUB_TRIG0)
            subtest_id = {TEST_BUS, 8'(n - 8'h04)};
        else if (s < SUB_SHORT0)
            subtest_id = {TEST_TRIG, 8'(n - 8'h06)};
        else
            subtest_id = {TEST_TRIG, 8'(n - 8'h04)};
    endfunction

    iot_state_t  state_r;
    iot_state_t  state_nxt;
    logic [4:0]  sub_r;
    logic [2:0]  src_r;
    logic [11:0] cnt_r;
    logic        bad_r;
    logic        det_r;
    logic        prev_r;
    logic        done_r;
    logic        fail_any_r;
    logic [15:0] fail_id_r;
    logic [7:0]  fail_cnt_r;
    logic [3:0]  norm_dout_r;
    logic [6:0]  norm_tout_r;

    // subtest groups
    wire       is_dio   = sub_r < SUB_DIN;
    wire       is_din   = sub_r == SUB_DIN;
    wire       is_hsk   = sub_r == SUB_HSK;
    wire       is_data  = sub_r == SUB_DATA;
    wire       is_short = sub_r >= SUB_SHORT0;
    wire       is_trig  = sub_r >= SUB_TRIG0;
    wire [4:0] trig_ofs = sub_r - SUB_TRIG0;
    wire [4:0] shrt_ofs = sub_r - SUB_SHORT0;
    wire [2:0] arm_idx  = is_short ? shrt_ofs[2:0] : trig_ofs[2:0];
    wire [2:0] src_sel  = is_short ? src_r : trig_ofs[2:0];
    wire [1:0] chk_bit  = sub_r[1:0] + 2'h1;                  // see [R3]
    wire       busy     = state_r != ST_IDLE && state_r != ST_DONE;

    // timing of each phase; a silent acceptor ends on the byte timeout
    // so that the sequence can never hang on the bus interface
    wire       first    = cnt_r == 12'h000;
    wire       settled  = cnt_r == SETTLE_CYC - 12'h001;
    wire       tmo_hit  = cnt_r == BYTE_TMO_CYC - 12'h001;
    wire       hsk_end  = (bus_byte_out_done && !first) || tmo_hit;
    wire       ph_end   = (is_hsk && state_r != ST_SETUP) ? hsk_end : settled;

    // trigger detector: armed line falls from its idle high level
    // prev_r restarts high at setup: a line stuck low counts as a trigger
    wire       arm_lvl  = trig_in_lines[arm_idx];                // see [R11]
    wire       det_hit  = prev_r && !arm_lvl;                    // see [R13]

    // expected outcome of a toggle phase
    wire       hi_ph    = state_r == ST_HI;
    logic      ph_ok;
    always_comb begin
        if (is_dio)
            ph_ok = out_port_in[chk_bit] == hi_ph;        // see [R5] see [R6]
        else if (is_din)
            ph_ok = dig_in_sample_bit || !hi_ph;                 // see [R8]
        else if (is_hsk)
            ph_ok = bus_byte_out_done;                           // see [R9]
        else if (is_data)
            ph_ok = bus_data_sample_bit != hi_ph;                // see [R10]
        else
            ph_ok = 1'b1;
    end

    // trigger verdict: lines 1-6 and get must fire, the rest must not
    wire       want_det = is_trig && !is_short && sub_r != SUB_XTRIG;
    wire       trig_bad = det_r != want_det;        // see [R14] see [R15]

    // next shorts source, skipping the armed line
    wire [3:0] src_p1   = {1'b0, src_r} + 4'h1;
    wire [3:0] src_p2   = (src_p1[2:0] == arm_idx) ? src_p1 + 4'h1 : src_p1;
    wire       src_more = !src_p2[3];
    wire [2:0] src_frst = (arm_idx == 3'h0) ? 3'h1 : 3'h0;

    // register access
    wire       wr_ctrl  = reg_wr && reg_addr == OFS_CTRL;
    wire       wr_norm  = reg_wr && reg_addr == OFS_NORM;
    wire       start    = wr_ctrl && reg_wdata[CTRL_START_BIT] &&
                          state_r == ST_IDLE;
    wire       rec_fail = state_r == ST_NEXT && bad_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (start)
                    state_nxt = ST_SETUP;
            end
            ST_SETUP: begin
                if (settled)
                    state_nxt = ST_HI;
            end
            ST_HI: begin
                if (ph_end)
                    state_nxt = ST_LO;
            end
            ST_LO: begin
                if (ph_end)
                    state_nxt = ST_EVAL;
            end
            ST_EVAL: begin
                if (is_short && src_more)
                    state_nxt = ST_HI;                           // see [R17]
                else
                    state_nxt = ST_NEXT;
            end
            ST_NEXT: begin
                if (sub_r == SUB_LAST)
                    state_nxt = ST_DONE;
                else
                    state_nxt = ST_SETUP;                        // see [R19]
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // the phase counter restarts at every change of state
    wire [11:0] cnt_nxt  = (state_nxt != state_r) ? 12'h000 :
                           cnt_r + 12'h001;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            cnt_r   <= 12'h000;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // sequence position
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sub_r <= 5'h00;
            src_r <= 3'h0;
        end else begin
            if (start)
                sub_r <= 5'h00;
            else if (state_r == ST_NEXT)
                sub_r <= sub_r + 5'h01;                          // see [R19]
            if (state_r == ST_SETUP)
                src_r <= src_frst;
            else if (state_r == ST_EVAL)
                src_r <= src_p2[2:0];
        end
    end

    // per-subtest verdict and the armed-input detector
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bad_r  <= 1'b0;
            det_r  <= 1'b0;
            prev_r <= 1'b1;
        end else if (state_r == ST_SETUP) begin
            bad_r  <= 1'b0;
            det_r  <= 1'b0;
            prev_r <= 1'b1;
        end else begin
            prev_r <= arm_lvl;
            if (det_hit)
                det_r <= 1'b1;
            if ((state_r == ST_HI || state_r == ST_LO) && ph_end && !ph_ok)
                bad_r <= 1'b1;
            if (state_r == ST_EVAL && is_trig && trig_bad)
                bad_r <= 1'b1;                              // see [R16]
        end
    end

    // overall result; the first failing subtest is kept
    // later failures only raise the count
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fail_any_r <= 1'b0;
            fail_id_r  <= FAIL_ID_RST;
            fail_cnt_r <= 8'h00;
            done_r     <= 1'b0;
        end else if (start) begin
            fail_any_r <= 1'b0;
            fail_id_r  <= FAIL_ID_RST;
            fail_cnt_r <= 8'h00;
            done_r     <= 1'b0;
        end else begin
            if (rec_fail) begin
                fail_any_r <= 1'b1;                              // see [R18]
                fail_cnt_r <= fail_cnt_r + 8'h01;
            end
            if (rec_fail && !fail_any_r)
                fail_id_r <= subtest_id(sub_r);                  // see [R18]
            if (state_r == ST_DONE)
                done_r <= 1'b1;
        end
    end

    // normal-mode levels of outputs and trigger lines
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            norm_dout_r <= NORM_DOUT_RST;
            norm_tout_r <= NORM_TOUT_RST;
        end else if (wr_norm) begin
            norm_dout_r <= reg_wdata[NORM_DOUT_LSB +: 4];
            norm_tout_r <= reg_wdata[NORM_TOUT_LSB +: 7];
        end
    end

    // pin levels; outside a test everything returns to normal drive
    wire [3:0] dio_mask  = sub_r[0] ? 4'ha : 4'h5;        // see [R5] see [R6]
    wire [3:0] dio_drv   = hi_ph ? 4'(4'h1 << sub_r[1:0]) : 4'h0;
    wire       dio_test  = busy && is_dio;                        // see [R7]
    wire [3:0] pout_nxt  = dio_test ? dio_drv : norm_dout_r;     // see [R2]
    wire [3:0] poe_n_nxt = dio_test ? ~dio_mask : 4'h0;          // see [R4]
    wire       trig_drv  = busy && is_trig && hi_ph && src_sel != SRC_GET;
    wire [6:0] tout_nxt  = !(busy && is_trig) ? norm_tout_r :
                           trig_drv ? 7'(7'h01 << src_sel) : 7'h00;
    wire       byte_go   = busy && first && (state_r == ST_HI ||
                           state_r == ST_LO) && (is_hsk || is_data);
    wire [7:0] byte_val  = is_hsk ? (hi_ph ? HSK_BYTE_A : HSK_BYTE_B) :
                           (hi_ph ? DIO1_DRIVE : DIO1_RELEASE);
    wire       get_go    = busy && is_trig && hi_ph && first &&
                           src_sel == SRC_GET;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_port_out_r   <= NORM_DOUT_RST;
            out_port_oe_n_r  <= 4'h0;
            trig_out_lines_r <= NORM_TOUT_RST;
            acceptor_en_r    <= 1'b0;
            bus_dout_r       <= 8'h00;
            bus_dout_wr_r    <= 1'b0;
            bus_get_cmd_r    <= 1'b0;
        end else begin
            out_port_out_r   <= pout_nxt;                        // see [R1]
            out_port_oe_n_r  <= poe_n_nxt;
            trig_out_lines_r <= tout_nxt;                        // see [R12]
            acceptor_en_r    <= busy && is_hsk;                  // see [R9]
            bus_dout_wr_r    <= byte_go;
            bus_get_cmd_r    <= get_go;                          // see [R16]
            if (byte_go)
                bus_dout_r <= byte_val;                          // see [R10]
        end
    end

    // readable words, assembled from the package's field positions
    logic [31:0] stat_word;
    logic [31:0] fail_word;
    logic [31:0] norm_word;
    always_comb begin
        stat_word                     = 32'h0000_0000;
        stat_word[STAT_BUSY_BIT]      = busy;
        stat_word[STAT_DONE_BIT]      = done_r;
        stat_word[STAT_FAIL_BIT]      = fail_any_r;
        fail_word                     = 32'h0000_0000;
        fail_word[15:0]               = fail_id_r;
        fail_word[FAIL_CNT_LSB +: 8]  = fail_cnt_r;
        norm_word                     = 32'h0000_0000;
        norm_word[NORM_DOUT_LSB +: 4] = norm_dout_r;
        norm_word[NORM_TOUT_LSB +: 7] = norm_tout_r;
    end

    // read data stand only in the cycle after the read strobe
    logic [31:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            OFS_STATUS: rd_mux = stat_word;
            OFS_FAIL:   rd_mux = fail_word;
            OFS_NORM:   rd_mux = norm_word;
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_r <= 32'h0000_0000;
            test_busy_r <= 1'b0;
            test_fail_r <= 1'b0;
        end else begin
            reg_rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
            test_busy_r <= busy;
            test_fail_r <= fail_any_r;
        end
    end

endmodule // iot_self_test

// ---- tb/iot_self_test_asserts.sv ----
// checker of the self-test sequencer outputs, bound to iot_self_test
// assumes the normal trigger outputs are left at zero during runs
module iot_self_test_asserts (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       reset_n,
    // observed ports
    input wire logic       reg_wr,
    input wire logic [3:0] out_port_out_r,
    input wire logic [3:0] out_port_oe_n_r,
    input wire logic [7:0] bus_dout_r,
    input wire logic       bus_dout_wr_r,
    input wire logic       bus_get_cmd_r,
    input wire logic [6:0] trig_out_lines_r,
    input wire logic       test_busy_r,
    input wire logic       test_fail_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    property p_oe_pair;
        out_port_oe_n_r inside {4'h0, 4'h5, 4'ha};
    endproperty
    a_oe_pair: assert property (p_oe_pair)
        else $error("port direction pattern not allowed");
    property p_drive_mask;
        test_busy_r |-> (out_port_out_r & out_port_oe_n_r) == 4'h0;
    endproperty
    a_drive_mask: assert property (p_drive_mask)
        else $error("input port bit carries a drive value");
    property p_idle_norm;
        (!test_busy_r && !$past(reg_wr)) |-> out_port_oe_n_r == 4'h0;
    endproperty
    a_idle_norm: assert property (p_idle_norm)
        else $error("port bits not all outputs while idle");
    property p_wr_byte;
        bus_dout_wr_r |-> bus_dout_r inside {8'h55, 8'haa, 8'h01, 8'h00}
            ##1 !bus_dout_wr_r;
    endproperty
    a_wr_byte: assert property (p_wr_byte)
        else $error("bad data-out byte or long write pulse");
    property p_get_pulse;
        bus_get_cmd_r |=> !bus_get_cmd_r && test_busy_r;
    endproperty
    a_get_pulse: assert property (p_get_pulse)
        else $error("group trigger command not a single pulse");
    property p_trig_one;
        test_busy_r |-> $onehot0(trig_out_lines_r);
    endproperty
    a_trig_one: assert property (p_trig_one)
        else $error("more than one trigger output on");
    property p_fail_sticky;
        $fell(test_fail_r) |-> $past(reg_wr) || $past(reg_wr, 2);
    endproperty
    a_fail_sticky: assert property (p_fail_sticky)
        else $error("fail flag dropped without a start");
    property p_busy_start;
        $rose(test_busy_r) |-> $past(reg_wr, 2);
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("busy rose without a start two cycles earlier");
endmodule // iot_self_test_asserts

// ---- tb/iot_far_model.sv ----
// far side of the sequencer: loopback network, acceptor, trigger wiring
// assumes one clock; fault and speed controls come from the bench
module iot_far_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // fault and speed controls
    input  wire logic [3:0] loop_brk,
    input  wire logic       xshort,
    input  wire logic       hs_mute,
    input  wire logic [9:0] hs_dly,
    input  wire logic       din_lo,
    // device pins
    input  wire logic [3:0] port_out,
    input  wire logic [3:0] port_oe_n,
    output logic      [3:0] port_in,
    output logic            din,
    output logic            dio1_smp,
    input  wire logic       acc_en,
    input  wire logic [7:0] dout,
    input  wire logic       dout_wr,
    input  wire logic       get_cmd,
    output logic            byte_done,
    input  wire logic [6:0] trig_out,
    output logic      [7:0] trig_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] fed;
    logic       dio1_r;
    logic       get_n_r;
    logic       pend_r;
    logic [9:0] cnt_r;

    // output n comes back on the next bit up, output four on bit a
    assign fed = {port_out[2:0] & ~loop_brk[2:0],
                  port_out[3] & ~loop_brk[3]};
    assign port_in = (~port_oe_n & port_out) | (port_oe_n & fed);
    // a dead pull-up lets the open input sit low
    assign din = ~din_lo;
    assign dio1_smp = ~dio1_r;
    // released lines float up; ext only sees channel ready through a short
    assign trig_in = {get_n_r, ~(xshort & trig_out[6]),
                      ~trig_out[5:0]};

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dio1_r <= 1'b0;
            get_n_r <= 1'b1;
            pend_r <= 1'b0;
            cnt_r <= 10'h000;
            byte_done <= 1'b0;
        end else begin
            get_n_r <= ~get_cmd;
            byte_done <= 1'b0;
            if (dout_wr) begin
                dio1_r <= dout[0];
                pend_r <= acc_en & ~hs_mute;
                cnt_r <= hs_dly;
            end else if (pend_r && cnt_r == 10'h000) begin
                pend_r <= 1'b0;
                byte_done <= 1'b1;
            end else if (pend_r) begin
                cnt_r <= cnt_r - 10'h001;
            end
        end
    end
endmodule // iot_far_model

// ---- tb/test_io_trigger_self_test.sv ----
// top bench of the self-test sequencer: register checks and whole runs
// assumes iot_far_model stands for the loopback and trigger wiring
module test_io_trigger_self_test;
    timeunit 1ns;
    timeprecision 1ps;
    import iot_pkg::*;
    typedef struct packed {
        logic [3:0]  brk;
        logic        xs;
        logic        mute;
        logic [9:0]  dly;
        logic [31:0] fl;
    } iot_run_t;
    // mute also kills the input pull-up: 103.5 fails first, 104.1 counts
    iot_run_t    runs [7] = '{
        '{4'h0, 1'b0, 1'b0, 10'h001, 32'h0},
        '{4'h0, 1'b0, 1'b0, 10'h12c, 32'h0},
        '{4'h2, 1'b0, 1'b0, 10'h001, 32'h16702},
        '{4'h4, 1'b0, 1'b0, 10'h001, 32'h16703},
        '{4'h8, 1'b0, 1'b0, 10'h001, 32'h16704},
        '{4'h0, 1'b1, 1'b0, 10'h001, 32'h16907},
        '{4'h0, 1'b0, 1'b1, 10'h001, 32'h26705}};
    logic              core_clk = 1'b0;
    logic              reset_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata_r;
    logic [DATA_W-1:0] rd_v;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [3:0]        out_port_in, out_port_out_r, out_port_oe_n_r;
    logic              dig_in_sample_bit, bus_data_sample_bit;
    logic              acceptor_en_r, bus_dout_wr_r, bus_get_cmd_r;
    logic [7:0]        bus_dout_r, trig_in_lines;
    logic              bus_byte_out_done, test_busy_r, test_fail_r;
    logic [6:0]        trig_out_lines_r;
    logic [3:0]        loop_brk = 4'h0;
    logic              xshort = 1'b0;
    logic              hs_mute = 1'b0;
    logic              din_lo = 1'b0;
    logic [9:0]        hs_dly = 10'h001;
    int                num_errors = 0;
    int                n_compared = 0;
    int                cyc = 0;

    always #12.5 core_clk = ~core_clk;

    iot_self_test dut_u (.core_clk, .reset_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata_r, .out_port_in, .out_port_out_r,
        .out_port_oe_n_r, .dig_in_sample_bit, .bus_data_sample_bit,
        .acceptor_en_r, .bus_dout_r, .bus_dout_wr_r, .bus_get_cmd_r,
        .bus_byte_out_done, .trig_out_lines_r, .trig_in_lines,
        .test_busy_r, .test_fail_r);
    iot_far_model far_u (.core_clk(core_clk), .reset_n(reset_n),
        .loop_brk(loop_brk), .xshort(xshort), .hs_mute(hs_mute),
        .hs_dly(hs_dly), .din_lo(din_lo), .port_out(out_port_out_r),
        .port_oe_n(out_port_oe_n_r), .port_in(out_port_in),
        .din(dig_in_sample_bit), .dio1_smp(bus_data_sample_bit),
        .acc_en(acceptor_en_r), .dout(bus_dout_r), .dout_wr(bus_dout_wr_r),
        .get_cmd(bus_get_cmd_r), .byte_done(bus_byte_out_done),
        .trig_out(trig_out_lines_r), .trig_in(trig_in_lines));

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata_r;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk($sformatf("reg %h", a), e, rd_v);
    endtask
    // a hang is caught by the cycle ceiling, so the poll may stop early
    task automatic run(input int i);
        int w;
        @(posedge core_clk);
        loop_brk <= runs[i].brk;
        xshort <= runs[i].xs;
        hs_mute <= runs[i].mute;
        hs_dly <= runs[i].dly;
        din_lo <= runs[i].mute;
        wr(OFS_CTRL, 32'h1);
        chk_rd(OFS_STATUS, 32'h1);
        chk("busy pin", 32'h1, {31'h0, test_busy_r});
        w = 0;
        do begin
            rd(OFS_STATUS);
            w++;
        end while (rd_v[STAT_DONE_BIT] !== 1'b1 && w < 40000);
        chk_rd(OFS_STATUS, runs[i].fl == 0 ? 32'h2 : 32'h6);
        chk_rd(OFS_FAIL, runs[i].fl);
        chk("fail pin", {31'h0, runs[i].fl != 0},
            {31'h0, test_fail_r});
        chk("busy pin", 32'h0, {31'h0, test_busy_r});
        chk("norm pins", 32'h9, {21'h0, trig_out_lines_r,
            out_port_out_r});
        chk("oe_n", 32'h0, {28'h0, out_port_oe_n_r});
        $display("test run %0d ended", i);
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 99000) begin
            num_errors++;
            $display("[FAIL] run length expected done seen hang");
            results();
        end
    end

    initial begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        chk_rd(OFS_STATUS, 32'h0);
        chk_rd(OFS_FAIL, 32'h0);
        chk_rd(OFS_CTRL, 32'h0);
        wr(8'h10, 32'h7ff);
        chk_rd(8'h10, 32'h0);
        chk_rd(OFS_NORM, 32'h0);
        wr(OFS_NORM, 32'h7ff);
        chk_rd(OFS_NORM, 32'h7ff);
        chk("norm pins", 32'h7ff, {21'h0, trig_out_lines_r,
            out_port_out_r});
        wr(OFS_NORM, 32'h9);
        $display("test registers ended");
        for (int i = 0; i < 7; i++)
            run(i);
        results();
    end
endmodule // test_io_trigger_self_test

bind iot_self_test iot_self_test_asserts chk_u (.core_clk, .reset_n,
    .reg_wr, .out_port_out_r, .out_port_oe_n_r, .bus_dout_r,
    .bus_dout_wr_r, .bus_get_cmd_r, .trig_out_lines_r, .test_busy_r,
    .test_fail_r);
